// ==== src/slpfs_pkg.sv ====
// Shared constants, level codes, pin functions and carrier types for the strap latch
package slpfs_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int PORT_COUNT = 4;   // Downstream ports 1 to 4
  localparam int PIN_FIRST  = 4;   // Lowest programmable pin number
  localparam int PIN_LAST   = 31;  // Highest programmable pin number
  localparam int LVL_W      = 3;   // Width of a detector level code
  localparam int PIN_IDX_W  = 5;   // Width of a pin number

  ////////////////////////////////////////////////////////////////////////////////
  // Resistor level codes from the analog detector
  localparam logic [2:0] LVL_WEAK_DOWN   = 3'h0;  // Weak pull-down
  localparam logic [2:0] LVL_WEAK_UP     = 3'h1;  // Weak pull-up
  localparam logic [2:0] LVL_STRONG_DOWN = 3'h2;  // Strong pull-down
  localparam logic [2:0] LVL_STRONG_UP   = 3'h3;  // Strong pull-up
  localparam logic [2:0] LVL_SHORT_GND   = 3'h4;  // Near short to ground

  ////////////////////////////////////////////////////////////////////////////////
  // Port masks, bit 0 is port 1
  localparam logic [3:0] MASK_NONE = 4'h0;  // No port
  localparam logic [3:0] MASK_P1   = 4'h1;  // Port 1
  localparam logic [3:0] MASK_P12  = 4'h3;  // Ports 1-2
  localparam logic [3:0] MASK_P123 = 4'h7;  // Ports 1-3
  localparam logic [3:0] MASK_ALL  = 4'hf;  // Ports 1-4

  ////////////////////////////////////////////////////////////////////////////////
  // Pin profiles
  typedef enum logic [1:0] {
    PROFILE_BRIDGE, PROFILE_AUDIO, PROFILE_SERIAL, PROFILE_FLEX
  } slpfs_profile_t;

  // Functions a programmable pin may carry
  typedef enum logic [5:0] {
    FN_GPIO, FN_DISCH_P1, FN_DISCH_P2,
    FN_CBLPWR_P1A, FN_CBLPWR_P1B, FN_CBLPWR_P2A, FN_CBLPWR_P2B,
    FN_PWR_P1, FN_PWR_P2, FN_PWR_P3, FN_PWR_P4,
    FN_FLASH_CS, FN_FLASH_CLK, FN_FLASH_D0, FN_FLASH_D1, FN_FLASH_D2, FN_FLASH_D3,
    FN_BRIDGE_SCL, FN_BRIDGE_SDA, FN_TARGET_SCL, FN_TARGET_SDA,
    FN_MICROPHONE_PLUG_DETECT, FN_AUDIO_IN, FN_AUDIO_WS, FN_AUDIO_OUT, FN_AUDIO_BCLK, FN_AUDIO_MCLK,
    FN_SER_RX, FN_SER_TX, FN_SER_CTS, FN_SER_DCD, FN_SER_RTS, FN_SER_DSR, FN_SER_DTR
  } slpfs_func_t;

  ////////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic [3:0] dplus_port_off_strap;       // D+ disable straps, bit 0 is port 1
    logic [3:0] dminus_port_off_strap;      // D- disable straps, bit 0 is port 1
    logic [2:0] fixed_port_count_strap;     // Non-removable level code
    logic [2:0] charging_port_count_strap;  // Charging level code
    logic [2:0] profile_strap_1;            // First pin-profile level code
    logic [2:0] profile_strap_2;            // Second pin-profile level code
  } slpfs_strap_t;

  typedef struct packed {
    logic [3:0]     hs_port_off;      // USB 2.0 port disabled
    logic [3:0]     ss_port_off;      // USB 3.0 port disabled
    logic [3:0]     fixed_ports;      // Non-removable ports
    logic [3:0]     charging_ports;   // Charging enabled ports
    slpfs_profile_t profile;          // Chosen pin profile
    logic           profile_reserved; // Reserved strap combination seen
  } slpfs_cfg_t;

endpackage

// ==== src/slpfs_strap_latch.sv ====
// Strap sampling, latching and default programmable pin function selection
module slpfs_strap_latch
  import slpfs_pkg::*;
(
  // Clock and reset
  input  wire logic                               sys_clk,
  input  wire logic                               reset_n,
  // Strap levels
  input  wire slpfs_strap_t                       strap,
  // Pin mux override writes
  input  wire logic                               mux_write,
  input  wire logic [PIN_IDX_W-1:0]               mux_write_pin,
  input  wire slpfs_func_t                        mux_write_func,
  // Latched configuration
  output slpfs_cfg_t                              cfg,
  output slpfs_func_t [PIN_LAST:PIN_FIRST]        pin_func
);

  ////////////////////////////////////////////////////////////////////////////////
  // Level code helpers

  // Map unknown codes onto the weak pull-down setting
  function automatic logic [2:0] clean_level(input logic [2:0] lvl);
    case (lvl)
      LVL_WEAK_DOWN, LVL_WEAK_UP, LVL_STRONG_DOWN,
      LVL_STRONG_UP, LVL_SHORT_GND: clean_level = lvl;
      default:                      clean_level = LVL_WEAK_DOWN;
    endcase
  endfunction

  // Turn a five-level code into a port mask starting at port 1
  function automatic logic [3:0] level_mask(input logic [2:0] lvl);
    case (clean_level(lvl))
      LVL_WEAK_UP:     level_mask = MASK_P1;
      LVL_STRONG_DOWN: level_mask = MASK_P12;
      LVL_STRONG_UP:   level_mask = MASK_P123;
      LVL_SHORT_GND:   level_mask = MASK_ALL;
      default:         level_mask = MASK_NONE;
    endcase
  endfunction

  // Default function of one pin under one profile
  function automatic slpfs_func_t default_func(input slpfs_profile_t prof, input int pin);
    slpfs_func_t f;
    f = FN_GPIO;
    case (pin)
      4:  f = FN_DISCH_P2;
      5:  f = FN_DISCH_P1;
      8:  f = FN_CBLPWR_P1A;
      9:  f = FN_CBLPWR_P1B;
      10: f = FN_CBLPWR_P2A;
      11: f = FN_CBLPWR_P2B;
      13: f = FN_PWR_P4;
      15: f = FN_PWR_P2;
      16: f = FN_PWR_P3;
      17: f = FN_PWR_P1;
      20: f = FN_FLASH_CS;
      21: f = FN_FLASH_CLK;
      22: f = FN_FLASH_D0;
      23: f = FN_FLASH_D1;
      24: f = FN_FLASH_D2;
      25: f = FN_FLASH_D3;
      default: f = FN_GPIO;
    endcase
    // Profile dependent pins; untouched pins keep the fixed default above
    unique case (prof)
      PROFILE_BRIDGE: begin
        if (pin == 18) f = FN_BRIDGE_SCL;
        if (pin == 19) f = FN_BRIDGE_SDA;
        if (pin == 26) f = FN_TARGET_SCL;
        if (pin == 27) f = FN_TARGET_SDA;
      end
      PROFILE_AUDIO: begin
        if (pin == 7)  f = FN_MICROPHONE_PLUG_DETECT;
        if (pin == 14) f = FN_AUDIO_IN;
        if (pin == 18) f = FN_AUDIO_WS;
        if (pin == 19) f = FN_AUDIO_OUT;
        if (pin == 26) f = FN_AUDIO_BCLK;
        if (pin == 27) f = FN_AUDIO_MCLK;
        if (pin == 30) f = FN_BRIDGE_SCL;
        if (pin == 31) f = FN_BRIDGE_SDA;
      end
      PROFILE_SERIAL: begin
        if (pin == 6)  f = FN_SER_RX;
        if (pin == 7)  f = FN_SER_TX;
        if (pin == 14) f = FN_SER_CTS;
        if (pin == 18) f = FN_SER_DCD;
        if (pin == 19) f = FN_SER_RTS;
        if (pin == 26) f = FN_SER_DSR;
        if (pin == 27) f = FN_SER_DTR;
      end
      PROFILE_FLEX: f = f;
    endcase
    return f;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Live decode of the straps

  wire logic [3:0]     port_off_live;     // Both disable straps high
  wire logic [2:0]     prof1_live;        // Cleaned first profile level
  wire logic [2:0]     prof2_live;        // Cleaned second profile level
  wire logic           prof_bad_live;     // Combination outside the four listed
  wire slpfs_profile_t profile_live;      // Profile chosen by straps
  wire slpfs_cfg_t     cfg_live;          // Full decoded configuration

  // Each line disables on a high; the port only when both lines do
  assign port_off_live = strap.dplus_port_off_strap & strap.dminus_port_off_strap;

  // Third profile strap has no input at all
  assign prof1_live    = clean_level(strap.profile_strap_1);
  assign prof2_live    = clean_level(strap.profile_strap_2);

  // Reserved combinations are flagged and fall back to profile 1
  assign prof_bad_live = (prof2_live != LVL_WEAK_DOWN) || (prof1_live == LVL_SHORT_GND);
  assign profile_live  = prof_bad_live ? PROFILE_BRIDGE : slpfs_profile_t'(prof1_live[1:0]);

  assign cfg_live.hs_port_off      = port_off_live;
  assign cfg_live.ss_port_off      = port_off_live;
  assign cfg_live.fixed_ports      = level_mask(strap.fixed_port_count_strap);
  assign cfg_live.charging_ports   = level_mask(strap.charging_port_count_strap);
  assign cfg_live.profile          = profile_live;
  assign cfg_live.profile_reserved = prof_bad_live;

  ////////////////////////////////////////////////////////////////////////////////
  // Latched configuration

  slpfs_cfg_t cfg_reg;  // Captured configuration

  // Track straps every cycle in reset, freeze at release
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cfg_reg <= cfg_live;
    end
  end

  assign cfg = cfg_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Programmable pin functions

  wire logic write_ok;  // Override names a real pin outside reset

  assign write_ok = reset_n && mux_write &&
                    (mux_write_pin >= PIN_IDX_W'(PIN_FIRST));

  genvar gp;
  generate
    for (gp = PIN_FIRST; gp <= PIN_LAST; gp++) begin : g_pin
      wire slpfs_func_t def_func;     // Default for this pin from live straps
      wire logic        hit;          // Override aimed at this pin
      slpfs_func_t      func_reg;     // Current function

      assign def_func = default_func(profile_live, gp);
      assign hit      = write_ok && (mux_write_pin == PIN_IDX_W'(gp));

      // Default loads in reset, overrides take effect afterwards
      always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
          func_reg <= def_func;
        end else if (hit) begin
          func_reg <= mux_write_func;
        end
      end

      assign pin_func[gp] = func_reg;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  a_disable_latch: assert property (@(posedge sys_clk)
    reset_n && !$past(reset_n) |->
      cfg.hs_port_off == $past(strap.dplus_port_off_strap & strap.dminus_port_off_strap))
    else $error("port disable not latched from both straps");

  a_ss_follows_hs: assert property (@(posedge sys_clk) disable iff (!reset_n)
    cfg.ss_port_off == cfg.hs_port_off)
    else $error("USB 3.0 disable differs from USB 2.0 disable");

  a_fixed_latch: assert property (@(posedge sys_clk)
    reset_n && !$past(reset_n) && $past(strap.fixed_port_count_strap) == LVL_STRONG_UP
      |-> cfg.fixed_ports == MASK_P123)
    else $error("non-removable decode wrong");

  a_charge_latch: assert property (@(posedge sys_clk)
    reset_n && !$past(reset_n) && $past(strap.charging_port_count_strap) > LVL_SHORT_GND
      |-> cfg.charging_ports == MASK_NONE)
    else $error("unknown charging code not treated as weak pull-down");

  a_cfg_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $past(reset_n) |-> cfg == $past(cfg))
    else $error("latched configuration changed outside reset");

  a_profile_latch: assert property (@(posedge sys_clk)
    reset_n && !$past(reset_n) && $past(strap.profile_strap_2) == LVL_WEAK_DOWN &&
      $past(strap.profile_strap_1) == LVL_STRONG_DOWN |-> cfg.profile == PROFILE_SERIAL)
    else $error("profile 3 not chosen");

  a_fixed_pins: assert property (@(posedge sys_clk)
    reset_n && !$past(reset_n) |->
      pin_func[4] == FN_DISCH_P2 && pin_func[17] == FN_PWR_P1 &&
      pin_func[20] == FN_FLASH_CS && pin_func[12] == FN_GPIO)
    else $error("fixed pin default wrong");

  a_profile_pins: assert property (@(posedge sys_clk)
    reset_n && !$past(reset_n) |->
      (cfg.profile == PROFILE_BRIDGE) == (pin_func[26] == FN_TARGET_SCL) &&
      (cfg.profile == PROFILE_AUDIO) == (pin_func[30] == FN_BRIDGE_SCL))
    else $error("profile pin default wrong");

  a_override_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
    write_ok && mux_write_pin == PIN_IDX_W'(9) |=> pin_func[9] == $past(mux_write_func))
    else $error("pin override not applied");

endmodule

// ==== tb/slpfs_board_straps.sv ====
// Board strap resistor model that drives the strap latch detector inputs
module slpfs_board_straps
  import slpfs_pkg::*;
(
  // Port disable ties to the supply, bit 0 is port 1
  input  wire logic [3:0]   dplus_tied,
  input  wire logic [3:0]   dminus_tied,
  // Resistor level codes fitted on the board
  input  wire logic [2:0]   fixed_lvl,
  input  wire logic [2:0]   charge_lvl,
  input  wire logic [2:0]   prof1_lvl,
  input  wire logic [2:0]   prof2_lvl,
  // Levels seen by the detector
  output wire slpfs_strap_t strap
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////////
  // A port is switched off by tying both of its data lines high
  assign strap.dplus_port_off_strap      = dplus_tied;
  assign strap.dminus_port_off_strap     = dminus_tied;
  // Passive resistors, always present, so the levels never float
  assign strap.fixed_port_count_strap    = fixed_lvl;
  assign strap.charging_port_count_strap = charge_lvl;
  // Only listed profile resistors, unless a scenario fits a reserved combination or an unknown code on purpose
  assign strap.profile_strap_1           = prof1_lvl;
  assign strap.profile_strap_2           = prof2_lvl;
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the strap latch and default pin function select
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import slpfs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Stimulus and observed signals
  logic                             sys_clk        = 1'b0;     // 125 MHz clock
  logic                             reset_n        = 1'b0;     // Held low at start
  logic [3:0]                       dp_t           = 4'h0;     // D+ ties
  logic [3:0]                       dm_t           = 4'h0;     // D- ties
  logic [2:0]                       fix_l          = 3'h0;     // Non-removable level
  logic [2:0]                       chg_l          = 3'h0;     // Charging level
  logic [2:0]                       p1_l           = 3'h0;     // First profile level
  logic [2:0]                       p2_l           = 3'h0;     // Second profile level
  logic                             mux_write      = 1'b0;     // Override strobe
  logic [PIN_IDX_W-1:0]             mux_write_pin  = 5'h00;    // Override pin
  slpfs_func_t                      mux_write_func = FN_GPIO;  // Override function
  slpfs_strap_t                     strap;                     // Board to latch
  slpfs_cfg_t                       cfg;                       // Latched settings
  slpfs_func_t [PIN_LAST:PIN_FIRST] pin_func;                  // Pin functions
  int                               failures       = 0;        // Mismatch count
  int                               n_tests        = 0;        // Comparison count
  // Pins whose function depends on the profile, and their functions per profile
  int                               var_pin [9]    = '{6, 7, 14, 18, 19, 26, 27, 30, 31};
  slpfs_func_t                      var_tab [4][9] = '{
    '{FN_GPIO, FN_GPIO, FN_GPIO, FN_BRIDGE_SCL, FN_BRIDGE_SDA,
      FN_TARGET_SCL, FN_TARGET_SDA, FN_GPIO, FN_GPIO},
    '{FN_GPIO, FN_MICROPHONE_PLUG_DETECT, FN_AUDIO_IN, FN_AUDIO_WS, FN_AUDIO_OUT,
      FN_AUDIO_BCLK, FN_AUDIO_MCLK, FN_BRIDGE_SCL, FN_BRIDGE_SDA},
    '{FN_SER_RX, FN_SER_TX, FN_SER_CTS, FN_SER_DCD, FN_SER_RTS,
      FN_SER_DSR, FN_SER_DTR, FN_GPIO, FN_GPIO},
    '{default: FN_GPIO}};

  // Clock with a period of 8 ns
  always #4 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////////
  // Board model and design
  slpfs_board_straps i_slpfs_board_straps (.dplus_tied(dp_t), .dminus_tied(dm_t),
    .fixed_lvl(fix_l), .charge_lvl(chg_l), .prof1_lvl(p1_l), .prof2_lvl(p2_l), .strap(strap));
  slpfs_strap_latch i_slpfs_strap_latch (.sys_clk(sys_clk), .reset_n(reset_n), .strap(strap),
    .mux_write(mux_write), .mux_write_pin(mux_write_pin), .mux_write_func(mux_write_func),
    .cfg(cfg), .pin_func(pin_func));

  ////////////////////////////////////////////////////////////////////////////////
  // Expected values and shared tasks
  // Port mask for a level code, unknown codes count as weak pull-down
  function automatic logic [3:0] exp_mask(input int c);
    return (c > 0 && c < 5) ? 4'hf >> (4 - c) : 4'h0;
  endfunction

  // Default function of pin n in profile p
  function automatic slpfs_func_t exp_fn(input int p, input int n);
    slpfs_func_t f;
    f = FN_GPIO;
    if (n == 4) f = FN_DISCH_P2;
    if (n == 5) f = FN_DISCH_P1;
    if (n >= 8 && n <= 11) f = slpfs_func_t'(int'(FN_CBLPWR_P1A) + n - 8);
    if (n == 13) f = FN_PWR_P4;
    if (n == 15 || n == 16) f = slpfs_func_t'(int'(FN_PWR_P2) + n - 15);
    if (n == 17) f = FN_PWR_P1;
    if (n >= 20 && n <= 25) f = slpfs_func_t'(int'(FN_FLASH_CS) + n - 20);
    for (int i = 0; i < 9; i++) begin
      if (var_pin[i] == n) f = var_tab[p][i];
    end
    return f;
  endfunction

  // Count one comparison and report a mismatch at once
  task automatic check(input bit ok, input string msg);
    n_tests++;
    if (!ok) begin
      failures++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  // Two reset edges, release, then one cycle for outputs to settle
  task automatic do_reset();
    @(negedge sys_clk);
    reset_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    reset_n = 1'b1;
    @(negedge sys_clk);
  endtask

  // One override write, held over one rising edge
  task automatic mux_wr(input logic [4:0] pin, input slpfs_func_t f);
    mux_write      = 1'b1;
    mux_write_pin  = pin;
    mux_write_func = f;
    @(negedge sys_clk);
  endtask

  // Profile straps in, profile, reserved flag and every pin default out
  task automatic prof_case(input logic [2:0] s1, input logic [2:0] s2, input int ep,
                           input logic er);
    p1_l = s1;
    p2_l = s2;
    do_reset();
    check(cfg.profile === slpfs_profile_t'(ep), "profile choice");
    check(cfg.profile_reserved === er, "reserved flag");
    for (int n = PIN_FIRST; n <= PIN_LAST; n++) begin
      check(pin_func[n] === exp_fn(ep, n), "pin default");
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  // Port off needs both lines high, and the USB 3.0 port follows
  task automatic t_port_off();
    for (int k = 0; k < 2; k++) begin
      dp_t = k ? 4'ha : 4'h5;
      dm_t = k ? 4'hf : 4'h3;
      do_reset();
      check(cfg.hs_port_off === (dp_t & dm_t), "port off pair");
      check(cfg.ss_port_off === (dp_t & dm_t), "paired port off");
    end
  endtask

  // Every level code on both count straps, unknown codes included
  task automatic t_levels();
    for (int c = 0; c < 8; c++) begin
      fix_l = 3'(c);
      chg_l = 3'(7 - c);
      do_reset();
      check(cfg.fixed_ports === exp_mask(c), "fixed ports");
      check(cfg.charging_ports === exp_mask(7 - c), "charge ports");
    end
  endtask

  // All four profiles, reserved combinations and an unknown second strap code
  task automatic t_profiles();
    for (int p = 0; p < 4; p++) begin
      prof_case(3'(p), 3'h0, p, 1'b0);
    end
    prof_case(3'h2, 3'h1, 0, 1'b1);
    prof_case(3'h4, 3'h0, 0, 1'b1);
    prof_case(3'h1, 3'h6, 1, 1'b0);
  endtask

  // Straps sampled on each reset edge, frozen once reset is released
  task automatic t_hold();
    @(negedge sys_clk);
    reset_n = 1'b0;
    fix_l   = 3'h1;
    @(negedge sys_clk);
    check(cfg.fixed_ports === 4'h1, "sampled in reset");
    fix_l = 3'h4;
    @(negedge sys_clk);
    reset_n = 1'b1;
    fix_l   = 3'h2;
    dp_t    = 4'hf;
    dm_t    = 4'hf;
    repeat (4) @(negedge sys_clk);
    check(cfg.fixed_ports === 4'hf, "held after release");
    check(cfg.hs_port_off === 4'ha, "port off held");
  endtask

  // Back-to-back overrides, a write to a pin below 4, then reset restores defaults
  task automatic t_override();
    slpfs_func_t ef;  // Expected function of one pin
    mux_wr(5'h09, FN_SER_TX);
    mux_wr(5'h1e, FN_AUDIO_IN);
    mux_wr(5'h02, FN_PWR_P1);
    mux_write = 1'b0;
    for (int n = PIN_FIRST; n <= PIN_LAST; n++) begin
      ef = (n == 9) ? FN_SER_TX : (n == 30) ? FN_AUDIO_IN : exp_fn(1, n);
      check(pin_func[n] === ef, "override");
    end
    // A write while reset is low is refused, the default loads instead
    @(negedge sys_clk);
    reset_n        = 1'b0;
    mux_write      = 1'b1;
    mux_write_pin  = 5'h09;
    mux_write_func = FN_SER_TX;
    @(negedge sys_clk);
    check(pin_func[9] === exp_fn(1, 9), "write in reset");
    mux_write = 1'b0;
    prof_case(3'h1, 3'h0, 1, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and run control
  task automatic tally_and_finish();
    $display("comparisons %0d, failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    #200000;
    failures++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    repeat (3) @(negedge sys_clk);
    reset_n = 1'b1;
    t_port_off();
    t_levels();
    t_profiles();
    t_hold();
    t_override();
    tally_and_finish();
  end
endmodule
